// >>> hw/cfg_pkg.sv
package cfg_pkg;
  // Universal I/O line functions
  typedef enum logic [1:0] {
    CFG_UIO_NONE      = 2'h0,
    CFG_UIO_RESET_IN  = 2'h1,
    CFG_UIO_FEEDBACK  = 2'h2,
    CFG_UIO_RESET_REQ = 2'h3
  } cfg_uio_fn_t;

  // Pair state, Gray coded along off -> armed -> verify -> on
  typedef enum logic [1:0] {
    CFG_OFF    = 2'b00,
    CFG_ARMED  = 2'b01,
    CFG_VERIFY = 2'b11,
    CFG_ON     = 2'b10
  } cfg_state_t;

  localparam int CFG_PAIRS_DEFAULT   = 2;
  localparam int CFG_UIO_DEFAULT     = 3;
  localparam int CFG_DEADLINE_CYCLES = 250;   // 10 us at 25 MHz
  localparam int CFG_SYNC_STAGES     = 3;
  localparam logic CFG_PAIR_RESET    = 1'b0;
endpackage : cfg_pkg

// >>> hw/cfg_sync_if.sv
`timescale 1ns/10ps
// Raw pins in, filtered levels out
interface cfg_sync_if #(parameter int W = 3);
  logic [W-1:0] raw;
  logic [W-1:0] level;
  modport owner (output raw, input level);
  modport filt  (input raw, output level);
endinterface : cfg_sync_if

// >>> hw/cfg_pin_sync.sv
`timescale 1ns/10ps
// Three-stage synchroniser; level changes when stages two and three agree
module cfg_pin_sync
  import cfg_pkg::*;
#(
  parameter int W = 3
) (
  input  wire logic ref_clk,
  input  wire logic rstn,
  cfg_sync_if.filt  sif
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] level;
  logic [W-1:0] next_level;

  // Stage one feeds only stage two
  always_comb begin
    next_level = level;
    for (int i = 0; i < W; i++) begin
      if (s2[i] == s3[i]) begin
        next_level[i] = s3[i];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s1    <= '0;
      s2    <= '0;
      s3    <= '0;
      level <= '0;
    end else begin
      s1    <= sif.raw;
      s2    <= s1;
      s3    <= s2;
      level <= next_level;
    end
  end

  assign sif.level = level;
endmodule : cfg_pin_sync

// >>> hw/cfg_contactor_gate.sv
`timescale 1ns/10ps
// Notes on behaviour
// R01: With monitoring enabled, feedback is checked before every switch-on attempt.
// R02: Feedback absent before switch-on keeps the pair OFF and flags contactor fault.
// R03: Feedback still asserted after switch-on forces the pair back OFF.
// R04: Contactors assert feedback only when both are at rest, contacts closed.
// R05: Monitoring is enabled or disabled separately for each output pair.
// R06: Each universal line acts as reset input, feedback input, or reset-required output.
// R07: With restart interlock, an OFF pair waits for reset press with field clear.
// R08: Post switch-on feedback deadline is a fixed parameterised cycle count.
module cfg_contactor_gate
  import cfg_pkg::*;
#(
  parameter int PAIRS    = CFG_PAIRS_DEFAULT,
  parameter int UIO      = CFG_UIO_DEFAULT,
  parameter int DEADLINE = CFG_DEADLINE_CYCLES
) (
  input  wire logic                 ref_clk,
  input  wire logic                 rstn,
  input  wire logic [PAIRS-1:0]     field_clear,
  input  wire logic [PAIRS-1:0]     monitor_enable,
  input  wire logic [PAIRS-1:0]     interlock_enable,
  input  wire logic [PAIRS-1:0]     fault_clear,
  input  wire logic [2*UIO-1:0]     uio_function,
  input  wire logic [UIO-1:0]       uio_pair_sel,
  input  wire logic [UIO-1:0]       uio_in,
  output logic      [UIO-1:0]       uio_out,
  output logic      [UIO-1:0]       uio_oe,
  output logic      [PAIRS-1:0]     safety_output_pair,
  output logic      [PAIRS-1:0]     contactor_fault
);
  // Counter wide enough to hold the full deadline value
  localparam int CW = $clog2(DEADLINE + 1);

  // Two pairs at most: the pair select is one bit per line
  initial begin
    if (PAIRS < 1 || PAIRS > 2 || UIO < 1 || DEADLINE < 1) begin
      $error("cfg_contactor_gate: unsupported parameter values");
    end
  end

  // Function code of line i
  function automatic cfg_uio_fn_t fn_of(input logic [2*UIO-1:0] f, input int i);
    fn_of = cfg_uio_fn_t'(f[2*i +: 2]);
  endfunction : fn_of

  // Pins are asynchronous; every line passes the filter, whatever its function.
  // Output-only lines are filtered too, which costs a few flops but keeps
  // the routing below uniform.
  cfg_sync_if #(.W(UIO)) sif ();
  assign sif.raw = uio_in;

  cfg_pin_sync #(.W(UIO)) cfg_pin_sync_i (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .sif     (sif)
  );

  // Route lines to pairs by function.
  // Several lines of one function on a pair are ORed: any line at the rest
  // level counts, so wire only one feedback line per pair.
  logic [PAIRS-1:0] feedback;
  logic [PAIRS-1:0] reset_lvl;
  always_comb begin
    feedback  = '0;
    reset_lvl = '0;
    for (int i = 0; i < UIO; i++) begin
      for (int p = 0; p < PAIRS; p++) begin
        if (int'(uio_pair_sel[i]) == p) begin
          if (fn_of(uio_function, i) == CFG_UIO_FEEDBACK) begin // R06
            feedback[p] = feedback[p] | sif.level[i];
          end
          if (fn_of(uio_function, i) == CFG_UIO_RESET_IN) begin // R06
            reset_lvl[p] = reset_lvl[p] | sif.level[i];
          end
        end
      end
    end
  end

  cfg_state_t       state      [PAIRS];
  cfg_state_t       next_state [PAIRS];
  logic [CW-1:0]    cnt        [PAIRS];
  logic [CW-1:0]    next_cnt   [PAIRS];
  logic [PAIRS-1:0] reset_prev;
  logic [PAIRS-1:0] fault;
  logic [PAIRS-1:0] next_fault;
  logic [PAIRS-1:0] pair_on;
  logic [PAIRS-1:0] next_pair_on;
  logic [PAIRS-1:0] need_reset;
  logic [PAIRS-1:0] press;
  logic [UIO-1:0]   next_uio_out;
  logic [UIO-1:0]   next_uio_oe;

  // Reset press is a rising edge of the filtered level.
  // Idle level of the button line is low, and the edge register resets low,
  // so no false press follows a reset.
  assign press = reset_lvl & ~reset_prev;

  // Per-pair sequencing.
  // OFF: waits for a switch-on attempt and checks the rest feedback.
  // ARMED: one-cycle recheck just before the outputs switch.
  // VERIFY: outputs on, feedback must leave the rest level in time.
  // ON: outputs follow the protective field only.
  // Fault clear is applied first so that a new fault in the same cycle wins.
  always_comb begin
    for (int p = 0; p < PAIRS; p++) begin
      next_state[p]   = state[p];
      next_cnt[p]     = cnt[p];
      next_fault[p]   = fault[p];
      next_pair_on[p] = 1'b0;
      need_reset[p]   = 1'b0;
      if (fault_clear[p]) begin
        next_fault[p] = 1'b0;
      end
      case (state[p])
        CFG_OFF: begin
          need_reset[p] = interlock_enable[p];
          // Switch-on request: field clear and, with interlock, a press
          if (field_clear[p] && (!interlock_enable[p] || press[p])) begin // R07
            if (monitor_enable[p] && !feedback[p]) begin // R01 R05
              next_fault[p] = 1'b1; // R02
            end else if (!fault[p] || fault_clear[p]) begin
              next_state[p] = CFG_ARMED;
            end
          end
        end
        CFG_ARMED: begin
          // Recheck at the switching edge; a weld may appear late
          if (!field_clear[p] || (monitor_enable[p] && !feedback[p])) begin // R01
            next_state[p] = CFG_OFF;
            // Builds on the cleared value; a late fault still sets
            next_fault[p] = next_fault[p] | (monitor_enable[p] & ~feedback[p]); // R02
          end else begin
            next_state[p]   = CFG_VERIFY;
            next_pair_on[p] = 1'b1;
            next_cnt[p]     = CW'(DEADLINE);
          end
        end
        CFG_VERIFY: begin
          // Deadline counts filtered feedback, so pin delay is inside it
          next_pair_on[p] = 1'b1;
          if (!field_clear[p]) begin
            next_state[p]   = CFG_OFF;
            next_pair_on[p] = 1'b0;
          end else if (!monitor_enable[p] || !feedback[p]) begin
            next_state[p] = CFG_ON;
          end else if (cnt[p] == CW'(1)) begin // R08
            next_state[p]   = CFG_OFF; // R03
            next_pair_on[p] = 1'b0;
            next_fault[p]   = 1'b1;
          end else begin
            next_cnt[p] = cnt[p] - CW'(1);
          end
        end
        CFG_ON: begin
          next_pair_on[p] = field_clear[p];
          if (!field_clear[p]) begin
            next_state[p] = CFG_OFF;
          end
        end
        default: begin
          next_state[p] = CFG_OFF;
        end
      endcase
    end
  end

  // Reset-required outputs driven on lines so configured
  always_comb begin
    for (int i = 0; i < UIO; i++) begin
      next_uio_oe[i]  = (fn_of(uio_function, i) == CFG_UIO_RESET_REQ); // R06
      next_uio_out[i] = 1'b0;
      for (int p = 0; p < PAIRS; p++) begin
        if (int'(uio_pair_sel[i]) == p && next_uio_oe[i]) begin
          next_uio_out[i] = need_reset[p] & field_clear[p];
        end
      end
    end
  end

  // State registers; outputs leave straight from these flops
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int p = 0; p < PAIRS; p++) begin
        state[p] <= CFG_OFF;
        cnt[p]   <= '0;
      end
      reset_prev         <= '0;
      fault              <= '0;
      pair_on            <= {PAIRS{CFG_PAIR_RESET}};
      uio_out            <= '0;
      uio_oe             <= '0;
    end else begin
      for (int p = 0; p < PAIRS; p++) begin
        state[p] <= next_state[p];
        cnt[p]   <= next_cnt[p];
      end
      reset_prev <= reset_lvl;
      fault      <= next_fault;
      pair_on    <= next_pair_on;
      uio_out    <= next_uio_out;
      uio_oe     <= next_uio_oe;
    end
  end

  // Registered outputs
  assign safety_output_pair = pair_on;
  assign contactor_fault    = fault;
endmodule : cfg_contactor_gate

// >>> bench/cfg_contactor_model.sv
`timescale 1ns/10ps
// Two guided contactors; rest contacts in series form the feedback line
module cfg_contactor_model (
  input  wire logic ref_clk,
  input  wire logic coil,
  input  wire logic weld,
  input  wire logic slow,
  output logic      fb
);
  logic [3:0] cnt = 4'h0;
  // Armature travel time; slow pickup outlasts the feedback deadline
  always_ff @(posedge ref_clk) cnt <= coil ? (cnt == 4'hF ? cnt : cnt + 4'h1) : 4'h0;
  // Rest level only when both armatures released and no contact welded
  assign fb = !weld && (cnt < (slow ? 4'hC : 4'h1));
endmodule : cfg_contactor_model

// >>> bench/cfg_gate_asserts.sv
`timescale 1ns/10ps
// Pair 0 only: line 0 reset press, line 1 feedback, line 2 reset-required
module cfg_gate_asserts #(
  parameter int PAIRS = 2, parameter int UIO = 3, parameter int DEADLINE = 8
) (
  input wire logic             ref_clk,
  input wire logic             rstn,
  input wire logic [PAIRS-1:0] field_clear,
  input wire logic [PAIRS-1:0] monitor_enable,
  input wire logic [PAIRS-1:0] interlock_enable,
  input wire logic [PAIRS-1:0] fault_clear,
  input wire logic [2*UIO-1:0] uio_function,
  input wire logic [UIO-1:0]   uio_pair_sel,
  input wire logic [UIO-1:0]   uio_in,
  input wire logic [UIO-1:0]   uio_out,
  input wire logic [UIO-1:0]   uio_oe,
  input wire logic [PAIRS-1:0] safety_output_pair,
  input wire logic [PAIRS-1:0] contactor_fault
);
  wire logic so  = safety_output_pair[0];
  wire logic fb  = uio_in[1];
  wire logic flt = contactor_fault[0];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Repetition of 8 matches the simulated deadline
  AST_FIELD_OFF: assert property (!field_clear[0] |=> !so)
    else $error("pair on after field blocked");
  AST_RISE_FIELD: assert property ($rose(so) |-> $past(field_clear[0]))
    else $error("pair rose without clear field");
  AST_NO_PRESS: assert property ((interlock_enable[0] && !uio_in[0])[*8] |-> !$rose(so))
    else $error("pair rose without reset press");
  AST_PRE_CHECK: assert property ((monitor_enable[0] && !fb)[*8] |-> !$rose(so))
    else $error("pair rose without rest feedback");
  AST_FAULT_BLOCK: assert property ($rose(so) |-> !flt)
    else $error("pair rose while fault set");
  AST_DEADLINE_OFF: assert property ($rose(so) && monitor_enable[0] && fb ##1
    (monitor_enable[0] && fb)[*8] |-> ##[1:3] !so)
    else $error("pair kept on with feedback stuck");
  AST_DEADLINE_FLT: assert property ($rose(so) && monitor_enable[0] && fb ##1
    (monitor_enable[0] && fb)[*8] |-> ##[1:3] flt)
    else $error("no fault after feedback stuck");
  AST_REQ_OE: assert property (uio_function[5:4] == 2'h3 |=> uio_oe[2])
    else $error("reset-required line not driven");
  AST_REQ_OUT: assert property ($rose(uio_out[2]) |-> $past(interlock_enable[0] && field_clear[0]))
    else $error("reset-required without interlock");
endmodule : cfg_gate_asserts
bind cfg_contactor_gate cfg_gate_asserts #(.PAIRS(PAIRS), .UIO(UIO), .DEADLINE(DEADLINE))
  cfg_gate_asserts_i (.*);

// >>> bench/contactor_feedback_gate_test.sv
`timescale 1ns/10ps
module contactor_feedback_gate_test;
  logic       ref_clk = 1'b0;
  logic       rstn = 1'b0;
  logic [1:0] field_clear = 2'h0, monitor_enable = 2'h1, interlock_enable = 2'h1;
  logic [1:0] fault_clear = 2'h0, sop, flt;
  logic       press = 1'b0, weld = 1'b0, slow = 1'b0, fb;
  logic [2:0] uio_out, uio_oe;
  int         fail_count = 0, checks_done = 0;
  wire  [2:0] uio_in = {1'b0, fb, press}; // Line 2 is an output, held low
  // 25 MHz
  always #20 ref_clk = ~ref_clk;
  cfg_contactor_gate #(.DEADLINE(8)) cfg_contactor_gate_i (.ref_clk(ref_clk), .rstn(rstn),
    .field_clear(field_clear), .monitor_enable(monitor_enable), .interlock_enable(interlock_enable),
    .fault_clear(fault_clear), .uio_function(6'h39), .uio_pair_sel(3'h0), .uio_in(uio_in),
    .uio_out(uio_out), .uio_oe(uio_oe), .safety_output_pair(sop), .contactor_fault(flt));
  cfg_contactor_model cfg_contactor_model_i (.ref_clk(ref_clk), .coil(sop[0]), .weld(weld),
    .slow(slow), .fb(fb));
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  // Press long enough to pass the pin filter
  task automatic push;
    press <= 1'b1;
    tick(6);
    press <= 1'b0;
    tick(6);
  endtask : push
  task automatic clr;
    fault_clear <= 2'h1;
    tick(1);
    fault_clear <= 2'h0;
  endtask : clr
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  // Pair 1 unmonitored and free running, pair 0 fully wired
  initial begin
    tick(20);
    rstn <= 1'b1;
    tick(2);
    chk({sop, flt}, 4'h0);
    chk({1'b0, uio_oe}, 4'h4);
    field_clear <= 2'h3;
    tick(8);
    chk({sop, flt}, 4'h8);
    chk({1'b0, uio_out}, 4'h4);
    push;
    chk({sop, flt}, 4'hC);
    // Slow pickup keeps rest contacts closed past the deadline
    slow <= 1'b1;
    field_clear <= 2'h2;
    tick(2);
    field_clear <= 2'h3;
    push;
    tick(6);
    chk({sop, flt}, 4'h9);
    push;
    chk({sop, flt}, 4'h9);
    // Welded contact never reports rest
    weld <= 1'b1;
    slow <= 1'b0;
    clr;
    push;
    chk({sop, flt}, 4'h9);
    monitor_enable <= 2'h0;
    clr;
    push;
    chk({sop, flt}, 4'hC);
    // Reset in mid-run drops both pairs; interlocked pair waits for a press
    rstn <= 1'b0;
    tick(2);
    chk({sop, flt}, 4'h0);
    rstn <= 1'b1;
    tick(2);
    chk({sop, flt}, 4'h0);
    tick(2);
    chk({sop, flt}, 4'h8);
    close_out;
  end
endmodule : contactor_feedback_gate_test
